// ### clock_ctl_pkg.sv
// Constants, field layout and carrier types of the system clock divider.
package clock_ctl_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CNT_W = 9;
    localparam int unsigned RTC_CNT_W = 10;

    localparam logic [ADDR_W-1:0] CLOCK_CTL_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] CLOCK_STATUS_OFFSET = 12'h004;

    // Bit 0 of the register is its most significant bit, so a field at
    // printed bits a..b sits at [31-a:31-b] here.
    localparam int unsigned DRIVE_LSB = 29;
    localparam int unsigned TB_SRC_BIT = 25;
    localparam int unsigned RTC_PREDIV_BIT = 24;
    localparam int unsigned RTC_INPUT_BIT = 23;
    localparam int unsigned WAKE_FAST_BIT = 21;
    localparam int unsigned EBD_LSB = 17;
    localparam int unsigned SYNC_LSB = 13;
    localparam int unsigned BAUD_LSB = 11;
    localparam int unsigned LOW_LSB = 8;
    localparam int unsigned HIGH_LSB = 5;

    localparam logic [1:0] DRIVE_FULL = 2'h0;
    localparam logic [1:0] DRIVE_HALF = 2'h1;
    localparam logic [1:0] DRIVE_RESERVED = 2'h2;
    localparam logic [1:0] DRIVE_OFF = 2'h3;
    localparam logic [2:0] LOW_RESERVED = 3'h6;
    localparam logic [2:0] HIGH_RESERVED = 3'h7;
    localparam logic [1:0] EBD_RESET = 2'h0;

    localparam logic [1:0] POR_LOAD_CNT = 2'h2;
    localparam logic [1:0] POR_DONE_CNT = 2'h3;

    localparam logic [3:0] TB_SYS_LAST = 4'hf;
    localparam logic [3:0] TB_OSC_LAST_16 = 4'hf;
    localparam logic [3:0] TB_OSC_LAST_4 = 4'h3;
    localparam logic [RTC_CNT_W-1:0] RTC_LAST_4 = 10'h003;
    localparam logic [RTC_CNT_W-1:0] RTC_LAST_512 = 10'h1ff;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic sys_clk_phase1;
        logic sys_clk_phase2;
        logic bus_clk_phase1;
        logic bus_clk_phase2;
        logic bus_clock_out;
        logic bus_clk_half_str;
        logic serial_sync_clk;
        logic serial_sync_clk_alt;
        logic baud_gen_clk;
        logic timebase_tick;
        logic rtc_tick;
    } clk_out_t;

endpackage

// ### clock_ctl_properties.sv
// Port-level assertions for the system clock divider and its register.
`timescale 1ns/1ps
`default_nettype none
module clock_ctl_properties
    import clock_ctl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus and pins
    input wire clock_ctl_pkg::apb_req_t apb_req,
    input wire clock_ctl_pkg::apb_rsp_t apb_rsp,
    input wire logic pll_locked,
    // Derived clocks
    input wire clock_ctl_pkg::clk_out_t clk_out
);
    localparam logic [31:0] RSVD = 32'h9C59_801F;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (
        apb_rsp.pready && apb_req.paddr != CLOCK_CTL_OFFSET
        && apb_req.paddr != CLOCK_STATUS_OFFSET
        |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_status_read_only: assert property (
        apb_rsp.pready && apb_req.pwrite
        && apb_req.paddr == CLOCK_STATUS_OFFSET |-> apb_rsp.pslverr)
        else $error("status write not refused");
    a_reserved_read_zero: assert property (
        apb_rsp.pready && !apb_req.pwrite
        && apb_req.paddr == CLOCK_CTL_OFFSET
        |-> (apb_rsp.prdata & RSVD) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    a_out_low_unlocked: assert property (
        !pll_locked [*5] |-> !clk_out.bus_clock_out)
        else $error("clock output active while unlocked");
    a_phase_order: assert property (
        clk_out.sys_clk_phase1 |-> !clk_out.sys_clk_phase2
        ##1 !clk_out.sys_clk_phase1)
        else $error("system phases overlap or run short");
    a_bus_in_sys: assert property (
        clk_out.bus_clk_phase2 |-> clk_out.sys_clk_phase2)
        else $error("bus phase off the system phase");
    a_half_pulse_only: assert property (
        clk_out.bus_clk_half_str && clk_out.bus_clock_out
        |-> clk_out.bus_clk_phase2)
        else $error("half strength output not following bus phase");
    a_sync_pair: assert property (
        clk_out.serial_sync_clk == clk_out.serial_sync_clk_alt)
        else $error("sync clock copies differ");

    c_ctl_write: cover property (apb_rsp.pready && apb_req.pwrite);
    c_refused: cover property (apb_rsp.pready && apb_rsp.pslverr);
    c_half: cover property (clk_out.bus_clk_half_str);
    c_timebase: cover property (clk_out.timebase_tick);
endmodule
bind system_clock_divider_control clock_ctl_properties i_props (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pll_locked(pll_locked), .clk_out(clk_out));
`default_nettype wire

// ### system_clock_divider_control.sv
// System clock divider, clock output control and clock control register.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Sync clock divides by 1, 4, 16, 64.
// - Baud clock divides by 1, 4, 16, 64.
// - Ratio changes keep lock and clocks running.
// - Low divisor 2..256, code 110 reserved.
// - High divisor 1..64, code 111 reserved.
// - Low divisor applies only with low select.
// - Resets clear sync, baud, low, high dividers, wake enable, drive.
// - Drive: full, half, reserved, off high.
// - Drive changes never glitch the output.
// - Output held low while PLL unlocked.
// - Bus divide by 1 or 2, from config at hard reset.
// - Wake requests force the high rate.
// - Timebase from oscillator or system/16.
// - Real-time prescale 4 or 512, strapped.
// - Real-time input strapped at power-on.
// - Sync clock resamples external serial clocks.
// - Two 32-bit memory-mapped registers: control and read-only status.
// - Low select chooses low else high rate.
// - Return to low rate once requests end.
module system_clock_divider_control #(
    parameter int unsigned SER_N = 2,
    parameter bit OSC_TB_DIV16 = 1'b1
) (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire clock_ctl_pkg::apb_req_t apb_req,
    output clock_ctl_pkg::apb_rsp_t apb_rsp,
    // Pins: hard reset, straps, lock, oscillator, external clocks
    input wire logic hard_reset_in_n,
    input wire logic [2:0] mode_clock_straps,
    input wire logic [1:0] ext_bus_div_cfg,
    input wire logic pll_locked,
    input wire logic osc_clk_in,
    input wire logic rtc_ext_clk_in,
    input wire logic [SER_N-1:0] ext_serial_clk_in,
    // Same-clock inputs from the core and power control
    input wire logic irq_pending,
    input wire logic core_power_save_bit,
    input wire logic low_speed_sel,
    // Derived clocks and synchronised serial clocks
    output clock_ctl_pkg::clk_out_t clk_out,
    output logic [SER_N-1:0] ser_clk_synced
);
    import clock_ctl_pkg::*;

    typedef struct packed {
        logic [1:0] clk_out_drive;
        logic timebase_src_sel;
        logic rtc_prediv_sel;
        logic rtc_input_sel;
        logic wake_fast_req_en;
        logic [1:0] ext_bus_div;
        logic [1:0] sync_div;
        logic [1:0] baud_div;
        logic [2:0] low_speed_div;
        logic [2:0] high_speed_div;
        apb_rsp_t rsp;
        logic hrst_s1;
        logic hrst_s2;
        logic lock_s1;
        logic lock_s2;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        logic [1:0] ebcfg_s1;
        logic [1:0] ebcfg_s2;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic rtcx_s1;
        logic rtcx_s2;
        logic rtcx_s3;
        logic [SER_N-1:0] ser_s1;
        logic [SER_N-1:0] ser_s2;
        logic [1:0] por_cnt;
        logic [CNT_W-1:0] sys_cnt;
        logic [CNT_W-1:0] sys_div_act;
        logic sys_low;
        logic bus_cnt;
        logic bus_ext_bus_div;
        logic [1:0] drive_act;
        logic [CNT_W-1:0] sync_cnt;
        logic [CNT_W-1:0] sync_div_act;
        logic [CNT_W-1:0] baud_cnt;
        logic [CNT_W-1:0] baud_div_act;
        logic [3:0] tb_cnt;
        logic [RTC_CNT_W-1:0] rtc_cnt;
        clk_out_t clk;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    // Counts 0 .. 2*div-1; a new ratio may be loaded when the count wraps.
    function automatic logic [CNT_W-1:0] div_next(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] div
    );
        logic [CNT_W:0] last;
        last = {div, 1'b0} - (CNT_W + 1)'(1);
        if ({1'b0, cnt} == last) begin
            return '0;
        end
        return cnt + 1'b1;
    endfunction

    // Codes 0..3 map to divisors 1, 4, 16, 64.
    function automatic logic [CNT_W-1:0] quad_div(input logic [1:0] code);
        return CNT_W'(1) << {code, 1'b0};
    endfunction

    function automatic logic [31:0] pack_ctl(input state_t st);
        logic [31:0] v;
        v = '0;
        v[DRIVE_LSB +: 2] = st.clk_out_drive;
        v[TB_SRC_BIT] = st.timebase_src_sel;
        v[RTC_PREDIV_BIT] = st.rtc_prediv_sel;
        v[RTC_INPUT_BIT] = st.rtc_input_sel;
        v[WAKE_FAST_BIT] = st.wake_fast_req_en;
        v[EBD_LSB +: 2] = st.ext_bus_div;
        v[SYNC_LSB +: 2] = st.sync_div;
        v[BAUD_LSB +: 2] = st.baud_div;
        v[LOW_LSB +: 3] = st.low_speed_div;
        v[HIGH_LSB +: 3] = st.high_speed_div;
        return v;
    endfunction

    always_comb begin
        logic setup;
        logic access;
        logic ctl_hit;
        logic fast_req;
        logic want_low;
        logic sys_wrap;
        logic osc_rise;
        logic rtcx_rise;
        logic tb_evt;
        logic [3:0] tb_last;
        logic rtc_evt;
        logic [RTC_CNT_W-1:0] rtc_last;
        setup = 1'b0;
        access = 1'b0;
        ctl_hit = 1'b0;
        fast_req = 1'b0;
        want_low = 1'b0;
        sys_wrap = 1'b0;
        osc_rise = 1'b0;
        rtcx_rise = 1'b0;
        tb_evt = 1'b0;
        tb_last = '0;
        rtc_evt = 1'b0;
        rtc_last = '0;
        nxt_state = state_ff;

        // Pin synchronisers; logic reads the second stage, and also the third for oscillator and rtc edges.
        nxt_state.hrst_s1 = hard_reset_in_n;
        nxt_state.hrst_s2 = state_ff.hrst_s1;
        nxt_state.lock_s1 = pll_locked;
        nxt_state.lock_s2 = state_ff.lock_s1;
        nxt_state.strap_s1 = mode_clock_straps;
        nxt_state.strap_s2 = state_ff.strap_s1;
        nxt_state.ebcfg_s1 = ext_bus_div_cfg;
        nxt_state.ebcfg_s2 = state_ff.ebcfg_s1;
        nxt_state.osc_s1 = osc_clk_in;
        nxt_state.osc_s2 = state_ff.osc_s1;
        nxt_state.osc_s3 = state_ff.osc_s2;
        nxt_state.rtcx_s1 = rtc_ext_clk_in;
        nxt_state.rtcx_s2 = state_ff.rtcx_s1;
        nxt_state.rtcx_s3 = state_ff.rtcx_s2;
        osc_rise = state_ff.osc_s2 & ~state_ff.osc_s3;
        rtcx_rise = state_ff.rtcx_s2 & ~state_ff.rtcx_s3;

        // Straps are caught once the synchroniser holds their settled value.
        if (state_ff.por_cnt != POR_DONE_CNT) begin
            nxt_state.por_cnt = state_ff.por_cnt + 2'h1;
        end
        if (state_ff.por_cnt == POR_LOAD_CNT) begin
            nxt_state.rtc_prediv_sel = state_ff.strap_s2[1] |
                                       state_ff.strap_s2[2];
            nxt_state.rtc_input_sel = state_ff.strap_s2[1];
        end

        // Zero-wait APB slave: ready is raised in the access phase.
        setup = apb_req.psel & ~apb_req.penable;
        access = apb_req.psel & apb_req.penable & state_ff.rsp.pready;
        ctl_hit = apb_req.paddr == CLOCK_CTL_OFFSET;
        nxt_state.rsp.pready = setup;
        if (setup) begin
            nxt_state.rsp.pslverr = ~ctl_hit &
                ~(apb_req.paddr == CLOCK_STATUS_OFFSET) | (~ctl_hit &
                apb_req.pwrite);
            nxt_state.rsp.prdata = '0;
            if (ctl_hit && !apb_req.pwrite) begin
                nxt_state.rsp.prdata = pack_ctl(state_ff);
            end else if (apb_req.paddr == CLOCK_STATUS_OFFSET &&
                         !apb_req.pwrite) begin
                nxt_state.rsp.prdata = {16'h0000, 3'h0, state_ff.sys_low,
                    state_ff.lock_s2, state_ff.bus_ext_bus_div,
                    state_ff.drive_act, state_ff.sys_div_act[7:0]};
            end
        end
        // Reserved bits are dropped on write and read back as zero.
        if (access && apb_req.pwrite && ctl_hit) begin
            nxt_state.clk_out_drive = apb_req.pwdata[DRIVE_LSB +: 2];
            nxt_state.timebase_src_sel = apb_req.pwdata[TB_SRC_BIT];
            nxt_state.rtc_prediv_sel = apb_req.pwdata[RTC_PREDIV_BIT];
            nxt_state.rtc_input_sel = apb_req.pwdata[RTC_INPUT_BIT];
            nxt_state.wake_fast_req_en = apb_req.pwdata[WAKE_FAST_BIT];
            nxt_state.ext_bus_div = apb_req.pwdata[EBD_LSB +: 2];
            nxt_state.sync_div = apb_req.pwdata[SYNC_LSB +: 2];
            nxt_state.baud_div = apb_req.pwdata[BAUD_LSB +: 2];
            nxt_state.low_speed_div = apb_req.pwdata[LOW_LSB +: 3];
            nxt_state.high_speed_div = apb_req.pwdata[HIGH_LSB +: 3];
        end

        // Hard reset wins over a bus write in the same cycle.
        if (!state_ff.hrst_s2) begin
            nxt_state.sync_div = '0;
            nxt_state.baud_div = '0;
            nxt_state.low_speed_div = '0;
            nxt_state.high_speed_div = '0;
            nxt_state.wake_fast_req_en = 1'b0;
            nxt_state.clk_out_drive = DRIVE_FULL;
            nxt_state.ext_bus_div = state_ff.ebcfg_s2;
        end

        // System clock rate selection.
        fast_req = state_ff.wake_fast_req_en &
                   (irq_pending | ~core_power_save_bit);
        want_low = low_speed_sel & ~fast_req;
        nxt_state.sys_cnt = div_next(state_ff.sys_cnt,
                                     state_ff.sys_div_act);
        sys_wrap = nxt_state.sys_cnt == '0;
        // A reserved code leaves the running ratio in place.
        if (sys_wrap) begin
            if (want_low && state_ff.low_speed_div != LOW_RESERVED) begin
                nxt_state.sys_div_act = CNT_W'(2) <<
                                        state_ff.low_speed_div;
                nxt_state.sys_low = 1'b1;
            end else if (!want_low &&
                         state_ff.high_speed_div != HIGH_RESERVED) begin
                nxt_state.sys_div_act = CNT_W'(1) <<
                                        state_ff.high_speed_div;
                nxt_state.sys_low = 1'b0;
            end
        end
        nxt_state.clk.sys_clk_phase1 = sys_wrap;
        nxt_state.clk.sys_clk_phase2 = nxt_state.sys_cnt ==
                                       nxt_state.sys_div_act;

        // Bus clocks: one or two system periods; drive changes wait here.
        if (sys_wrap) begin
            if (state_ff.bus_cnt == state_ff.bus_ext_bus_div) begin
                nxt_state.bus_cnt = 1'b0;
                if (!state_ff.ext_bus_div[1]) begin
                    nxt_state.bus_ext_bus_div = state_ff.ext_bus_div[0];
                end
                if (state_ff.clk_out_drive != DRIVE_RESERVED) begin
                    nxt_state.drive_act = state_ff.clk_out_drive;
                end
            end else begin
                nxt_state.bus_cnt = 1'b1;
            end
        end
        nxt_state.clk.bus_clk_phase1 = nxt_state.clk.sys_clk_phase1 &
                                       ~nxt_state.bus_cnt;
        nxt_state.clk.bus_clk_phase2 = nxt_state.clk.sys_clk_phase2 &
                                       (nxt_state.bus_cnt ==
                                        nxt_state.bus_ext_bus_div);
        if (!state_ff.lock_s2) begin
            nxt_state.clk.bus_clock_out = 1'b0;
        end else if (nxt_state.drive_act == DRIVE_OFF) begin
            nxt_state.clk.bus_clock_out = 1'b1;
        end else begin
            nxt_state.clk.bus_clock_out = nxt_state.clk.bus_clk_phase2;
        end
        nxt_state.clk.bus_clk_half_str = nxt_state.drive_act ==
                                         DRIVE_HALF;

        // Serial sync clock, loaded only at its own period boundary.
        nxt_state.sync_cnt = div_next(state_ff.sync_cnt,
                                      state_ff.sync_div_act);
        if (nxt_state.sync_cnt == '0) begin
            nxt_state.sync_div_act = quad_div(state_ff.sync_div);
            // External serial clocks are resampled on the sync clock edge.
            nxt_state.ser_s1 = ext_serial_clk_in;
            nxt_state.ser_s2 = state_ff.ser_s1;
        end
        nxt_state.clk.serial_sync_clk = nxt_state.sync_cnt <
                                        nxt_state.sync_div_act;
        nxt_state.clk.serial_sync_clk_alt = nxt_state.clk.serial_sync_clk;

        // Baud generator clock.
        nxt_state.baud_cnt = div_next(state_ff.baud_cnt,
                                      state_ff.baud_div_act);
        if (nxt_state.baud_cnt == '0) begin
            nxt_state.baud_div_act = quad_div(state_ff.baud_div);
        end
        nxt_state.clk.baud_gen_clk = nxt_state.baud_cnt <
                                     nxt_state.baud_div_act;

        // Timebase tick source.
        if (state_ff.timebase_src_sel) begin
            tb_evt = sys_wrap;
            tb_last = TB_SYS_LAST;
        end else begin
            tb_evt = osc_rise;
            tb_last = OSC_TB_DIV16 ? TB_OSC_LAST_16 : TB_OSC_LAST_4;
        end
        nxt_state.clk.timebase_tick = 1'b0;
        if (tb_evt) begin
            if (state_ff.tb_cnt >= tb_last) begin
                nxt_state.tb_cnt = '0;
                nxt_state.clk.timebase_tick = 1'b1;
            end else begin
                nxt_state.tb_cnt = state_ff.tb_cnt + 4'h1;
            end
        end

        // Real-time clock prescaler.
        rtc_evt = state_ff.rtc_input_sel ? rtcx_rise : osc_rise;
        rtc_last = state_ff.rtc_prediv_sel ? RTC_LAST_512 :
                   RTC_LAST_4;
        nxt_state.clk.rtc_tick = 1'b0;
        if (rtc_evt) begin
            if (state_ff.rtc_cnt >= rtc_last) begin
                nxt_state.rtc_cnt = '0;
                nxt_state.clk.rtc_tick = 1'b1;
            end else begin
                nxt_state.rtc_cnt = state_ff.rtc_cnt + 10'h001;
            end
        end
    end

    // Power-on reset puts every divider at its fastest, full-drive setting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
            state_ff.hrst_s1 <= 1'b1;
            state_ff.hrst_s2 <= 1'b1;
            state_ff.sys_div_act <= CNT_W'(1);
            state_ff.sync_div_act <= CNT_W'(1);
            state_ff.baud_div_act <= CNT_W'(1);
            state_ff.ext_bus_div <= EBD_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign apb_rsp = state_ff.rsp;
    assign clk_out = state_ff.clk;
    assign ser_clk_synced = state_ff.ser_s2;

endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the system clock divider and its register.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clock_ctl_pkg::*;
    logic pclk, presetn, hard_reset_in_n, pll_locked;
    logic osc_clk_in, rtc_ext_clk_in, irq_pending;
    logic core_power_save_bit, low_speed_sel;
    logic [2:0] mode_clock_straps;
    logic [1:0] ext_bus_div_cfg, ext_serial_clk_in, ser_sync;
    apb_req_t req;
    apb_rsp_t rsp;
    clk_out_t co;
    logic [31:0] q;
    logic e;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    system_clock_divider_control #(.SER_N(2), .OSC_TB_DIV16(1'b1)) i_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .hard_reset_in_n(hard_reset_in_n),
        .mode_clock_straps(mode_clock_straps),
        .ext_bus_div_cfg(ext_bus_div_cfg), .pll_locked(pll_locked),
        .osc_clk_in(osc_clk_in), .rtc_ext_clk_in(rtc_ext_clk_in),
        .ext_serial_clk_in(ext_serial_clk_in), .irq_pending(irq_pending),
        .core_power_save_bit(core_power_save_bit),
        .low_speed_sel(low_speed_sel), .clk_out(co),
        .ser_clk_synced(ser_sync));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Slow pins: oscillator period 10 cycles, external rtc period 8.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        osc_clk_in <= (cyc % 10) < 5;
        rtc_ext_clk_in <= (cyc % 8) < 4;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x,
        input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    function automatic logic [31:0] fld(input logic [2:0] v,
        input int unsigned l);
        return 32'(v) << l;
    endfunction
    function automatic logic pick(input int s);
        case (s)
            0: return co.sys_clk_phase1;
            1: return co.serial_sync_clk;
            2: return co.baud_gen_clk;
            3: return co.bus_clk_phase1;
            4: return co.timebase_tick;
            default: return co.rtc_tick;
        endcase
    endfunction
    // Skips to a fresh edge first, since a new ratio lands only at a wrap.
    task automatic per(input int s, input logic [31:0] x);
        int n;
        logic p;
        repeat (3) begin
            n = 0;
            do begin
                p = pick(s);
                @(negedge pclk);
                n++;
            end while (!(p === 1'b0 && pick(s) === 1'b1) && n < 6000);
        end
        chk("period", x, 32'(n));
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        // Ready is read at the rising edge, before that edge updates it.
        do begin
            @(posedge pclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        if (rsp.pready !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic set(input logic [31:0] v);
        apb(1'b1, CLOCK_CTL_OFFSET, v);
    endtask
    task automatic rd(input logic [31:0] x);
        apb(1'b0, CLOCK_CTL_OFFSET, 32'h0000_0000);
        chk("control", x, q);
    endtask

    task automatic t_regs();
        apb(1'b0, CLOCK_STATUS_OFFSET, 32'h0000_0000);
        chk("status", 32'h0000_0801, q);
        rd(fld(1, RTC_PREDIV_BIT));
        per(5, 5120);
        set(32'hBFFB_F7DF);
        rd(32'h23A2_77C0);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("slverr", 1, e);
        apb(1'b1, CLOCK_STATUS_OFFSET, 32'h0000_0000);
        chk("slverr", 1, e);
        rd(32'h23A2_77C0);
    endtask
    task automatic t_sys();
        for (int c = 0; c < 7; c++) begin
            set(fld(c, HIGH_LSB));
            per(0, 2 << c);
        end
        set(fld(7, HIGH_LSB));
        per(0, 128);
        for (int c = 0; c < 3; c++) begin
            set(fld(c, EBD_LSB));
            per(3, c == 0 ? 2 : 4);
        end
        set(fld(3, LOW_LSB));
        per(0, 2);
        @(posedge pclk);
        low_speed_sel <= 1'b1;
        per(0, 32);
        for (int c = 0; c < 8; c++) begin
            set(fld(c, LOW_LSB));
            per(0, c == 6 ? 128 : 4 << c);
        end
    endtask
    task automatic t_wake();
        set(fld(1, WAKE_FAST_BIT));
        per(0, 4);
        @(posedge pclk);
        irq_pending <= 1'b1;
        per(0, 2);
        @(posedge pclk);
        irq_pending <= 1'b0;
        core_power_save_bit <= 1'b0;
        per(0, 2);
        set(0);
        per(0, 4);
        @(posedge pclk);
        core_power_save_bit <= 1'b1;
        low_speed_sel <= 1'b0;
    endtask
    task automatic t_serial();
        for (int c = 0; c < 4; c++) begin
            set(fld(c, SYNC_LSB) | fld(3 - c, BAUD_LSB)
                | fld(2 * c, HIGH_LSB));
            per(1, 2 << (2 * c));
            per(2, 2 << (2 * (3 - c)));
        end
        set(0);
        per(1, 2);
        for (int c = 1; c < 3; c++) begin
            @(posedge pclk);
            ext_serial_clk_in <= c[1:0];
            repeat (8) @(posedge pclk);
            chk("synced", c, ser_sync);
        end
    endtask
    task automatic t_timers();
        set(fld(1, TB_SRC_BIT));
        per(4, 32);
        set(0);
        per(4, 160);
        set(fld(1, RTC_INPUT_BIT));
        per(5, 32);
        set(0);
        per(5, 40);
    endtask
    task automatic t_out();
        set(fld(1, DRIVE_LSB));
        repeat (8) @(posedge pclk);
        chk("half", 1, co.bus_clk_half_str);
        set(fld(3, DRIVE_LSB));
        repeat (8) @(posedge pclk);
        repeat (8) begin
            @(negedge pclk);
            chk("bus_clock_out", 1, co.bus_clock_out);
        end
        @(posedge pclk);
        pll_locked <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("bus_clock_out", 0, co.bus_clock_out);
        pll_locked <= 1'b1;
        set(fld(1, DRIVE_LSB) | fld(1, TB_SRC_BIT) | fld(1, WAKE_FAST_BIT)
            | fld(3, SYNC_LSB) | fld(2, BAUD_LSB) | fld(5, LOW_LSB)
            | fld(4, HIGH_LSB));
        hard_reset_in_n <= 1'b0;
        repeat (6) @(posedge pclk);
        set(fld(1, DRIVE_LSB) | fld(1, TB_SRC_BIT));
        hard_reset_in_n <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(fld(1, TB_SRC_BIT) | fld(1, EBD_LSB));
    endtask

    initial begin
        presetn = 1'b0;
        hard_reset_in_n = 1'b1;
        pll_locked = 1'b1;
        {osc_clk_in, rtc_ext_clk_in, irq_pending, low_speed_sel} = 4'h0;
        core_power_save_bit = 1'b1;
        mode_clock_straps = 3'b100;
        ext_bus_div_cfg = 2'b01;
        ext_serial_clk_in = 2'b00;
        req = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_sys();
        t_wake();
        t_serial();
        t_timers();
        t_out();
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
